// file: hw/rcg_params.svh
// Constants for the remote input command gate
`ifndef RCG_PARAMS_SVH
`define RCG_PARAMS_SVH

// Pins 0 to 7 carry the remote functions
`define RCG_NPIN       8
`define RCG_IDXW       3
`define RCG_NFUNC      11
`define RCG_NSTAT      6
`define RCG_FNUMW      3

// Initial input map, three bits per function, start in the low field
`define RCG_IN_MAP_INIT  33'h0_00fa_c688
`define RCG_IN_ASGN_INIT 11'h0ff
// Initial output map: ready 0, running 1, paused 2, error 3, estop 4, guard 5
`define RCG_OUT_MAP_INIT 18'h2c688

`endif

// file: hw/rcg_pkg.sv
// Types for the remote input command gate
package rcg_pkg;

  // Remote input functions, order fixes the field in the input map
  typedef enum logic [3:0] {
    FN_START,
    FN_SEL1,
    FN_SEL2,
    FN_SEL4,
    FN_STOP,
    FN_PAUSE,
    FN_CONT,
    FN_RESET,
    FN_MON,
    FN_MOFF,
    FN_HOME
  } rcg_func_t;

  // Status outputs, order fixes the field in the output map
  typedef enum logic [2:0] {
    ST_READY,
    ST_RUNNING,
    ST_PAUSED,
    ST_ERROR,
    ST_ESTOP,
    ST_GUARD
  } rcg_stat_t;

  typedef logic [2:0] rcg_fnum_t;

endpackage : rcg_pkg

// file: hw/rcg_gate.sv
// Remote input command gate: pin sync, edge detect, acceptance and status map
//
// Notes on behaviour
// - Functions map onto pins 0-7, remappable.
// - Remote honoured only with virtual I/O enabled.
// - Remote-enabled output high when remote accepted.
// - Commands fire on asserting edge if accepted.
// - Pending error blocks all but reset.
// - Start needs ready, no error/estop/guard/pause/stop.
// - Stop halts everything, remote mode only.
// - Pause accepted only while running.
// - Continue needs paused, pause and stop low.
// - Reset clears error, needs ready.
// - Motor on needs ready, no estop/guard/off.
// - Motor off accepted only while ready.
// - Home needs ready, motors, no fault, pause/stop.
// - Select bits weigh 1, 2, 4.
// - Remote-enabled output gates every command.
// - Error output holds until accepted reset.
`timescale 1ns/1ns
`include "rcg_params.svh"

module rcg_gate #(
  parameter int NPIN  = `RCG_NPIN,
  parameter int IDXW  = `RCG_IDXW,
  parameter int NFUNC = `RCG_NFUNC,
  parameter int NSTAT = `RCG_NSTAT
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic [NPIN-1:0]         pin_i,
  input  wire logic                    virtual_io_en_i,
  input  wire logic                    remote_assigned_i,
  input  wire logic                    remote_source_i,
  input  wire logic [NFUNC*IDXW-1:0]   in_map_i,
  input  wire logic [NFUNC-1:0]        in_assigned_i,
  input  wire logic [NSTAT*IDXW-1:0]   out_map_i,
  input  wire logic                    ready_i,
  input  wire logic                    running_i,
  input  wire logic                    paused_i,
  input  wire logic                    emergency_stop_active_i,
  input  wire logic                    guard_open_active_i,
  input  wire logic                    motors_energised_i,
  input  wire logic                    error_event_i,
  output logic      [NPIN-1:0]         pin_o,
  output logic                         remote_enabled_out_o,
  output logic                         error_o,
  output logic                         start_o,
  output rcg_pkg::rcg_fnum_t           func_num_o,
  output logic                         stop_o,
  output logic                         pause_o,
  output logic                         continue_o,
  output logic                         reset_o,
  output logic                         motor_power_on_cmd_o,
  output logic                         motor_power_off_cmd_o,
  output logic                         home_o
);
  import rcg_pkg::*;

  logic [1:0]       rst_pipe;
  logic             rst_n;
  logic [NPIN-1:0]  sync1;
  logic [NPIN-1:0]  sync2;
  logic [NPIN-1:0]  sync3;
  logic [NPIN-1:0]  lvl;
  logic [NFUNC-1:0] fl;
  logic [NFUNC-1:0] fl_prev;
  logic [NFUNC-1:0] rise;
  logic [NSTAT-1:0] stat;
  logic [NPIN-1:0]  next_pin;
  logic             err;
  logic             remote_en;
  logic             cmd_ok;
  logic             acc_start;
  logic             acc_stop;
  logic             acc_pause;
  logic             acc_cont;
  logic             acc_reset;
  logic             acc_mon;
  logic             acc_moff;
  logic             acc_home;
  logic             no_fault;

  // Field of a packed map
  function automatic logic [IDXW-1:0] map_field(input logic [NFUNC*IDXW-1:0] m,
                                                input int f);
    map_field = m[f*IDXW +: IDXW];
  endfunction : map_field

  // Pin index of a status in the packed output map
  function automatic logic [IDXW-1:0] stat_field(input logic [NSTAT*IDXW-1:0] m,
                                                 input int s);
    stat_field = m[s*IDXW +: IDXW];
  endfunction : stat_field

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Three flop synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lvl <= '0;
    end else begin
      for (int p = 0; p < NPIN; p++) begin
        if (sync2[p] == sync3[p]) begin
          lvl[p] <= sync3[p];
        end
      end
    end
  end

  // Pick each function from its configured pin; unassigned functions stay low
  always_comb begin
    for (int f = 0; f < NFUNC; f++) begin
      fl[f] = in_assigned_i[f] & lvl[map_field(in_map_i, f)];
    end
  end

  // Edge history per function, so a remap alone cannot fire twice
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fl_prev <= '0;
    end else begin
      fl_prev <= fl;
    end
  end
  assign rise = fl & ~fl_prev;

  // Remote mode is registered so acceptance sees exactly what the pin shows
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      remote_enabled_out_o <= 1'b0;
    end else begin
      remote_enabled_out_o <= virtual_io_en_i & remote_assigned_i
                              & remote_source_i;
    end
  end
  assign remote_en = remote_enabled_out_o;

  // Acceptance, evaluated in the same cycle as the detected edge
  assign cmd_ok    = remote_en & ~err;
  assign no_fault  = ~emergency_stop_active_i & ~guard_open_active_i;
  assign acc_start = rise[FN_START] & cmd_ok & ready_i & no_fault
                     & ~fl[FN_PAUSE] & ~fl[FN_STOP];
  assign acc_stop  = rise[FN_STOP] & cmd_ok;
  assign acc_pause = rise[FN_PAUSE] & cmd_ok & running_i;
  assign acc_cont  = rise[FN_CONT] & cmd_ok & paused_i
                     & ~fl[FN_PAUSE] & ~fl[FN_STOP];
  assign acc_reset = rise[FN_RESET] & remote_en & ready_i;
  assign acc_mon   = rise[FN_MON] & cmd_ok & ready_i & no_fault
                     & ~fl[FN_MOFF];
  assign acc_moff  = rise[FN_MOFF] & cmd_ok & ready_i;
  assign acc_home  = rise[FN_HOME] & cmd_ok & ready_i & no_fault
                     & motors_energised_i & ~fl[FN_PAUSE] & ~fl[FN_STOP];

  // Error holds until an accepted reset; a new error in that cycle wins
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      err <= 1'b0;
    end else begin
      err <= error_event_i | (err & ~acc_reset);
    end
  end
  assign error_o = err;

  // One cycle command pulses
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      start_o               <= 1'b0;
      stop_o                <= 1'b0;
      pause_o               <= 1'b0;
      continue_o            <= 1'b0;
      reset_o               <= 1'b0;
      motor_power_on_cmd_o  <= 1'b0;
      motor_power_off_cmd_o <= 1'b0;
      home_o                <= 1'b0;
    end else begin
      start_o               <= acc_start;
      stop_o                <= acc_stop;
      pause_o               <= acc_pause;
      continue_o            <= acc_cont;
      reset_o               <= acc_reset;
      motor_power_on_cmd_o  <= acc_mon;
      motor_power_off_cmd_o <= acc_moff;
      home_o                <= acc_home;
    end
  end

  // Function number captured with start; it holds until the next start
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      func_num_o <= '0;
    end else if (acc_start) begin
      func_num_o <= {fl[FN_SEL4], fl[FN_SEL2], fl[FN_SEL1]};
    end
  end

  // Status onto configured output pins; two statuses on one pin are ORed
  assign stat = {guard_open_active_i, emergency_stop_active_i, err,
                 paused_i, running_i, ready_i};

  always_comb begin
    next_pin = '0;
    for (int s = 0; s < NSTAT; s++) begin
      next_pin[stat_field(out_map_i, s)] = next_pin[stat_field(out_map_i, s)]
                                           | stat[s];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_o <= '0;
    end else begin
      pin_o <= next_pin;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_stop_edge;
    !fl[FN_STOP] ##1 fl[FN_STOP];
  endsequence

  sequence s_start_edge;
    !fl[FN_START] ##1 fl[FN_START];
  endsequence

  sequence s_pin_settle;
    sync3[0] ##1 sync3[0];
  endsequence

  a_vio_off_gate: assert property (!virtual_io_en_i |=> !remote_enabled_out_o)
    else $error("remote enabled with virtual io off");
  a_remote_en_out: assert property (
    virtual_io_en_i && remote_assigned_i && remote_source_i |=> remote_enabled_out_o)
    else $error("remote enabled output missing");
  a_stop_once: assert property (stop_o |=> !stop_o)
    else $error("stop fired twice for one edge");
  a_error_blocks: assert property (err |=> !(start_o || stop_o || pause_o
    || continue_o || motor_power_on_cmd_o || motor_power_off_cmd_o || home_o))
    else $error("command passed while error pending");
  a_start_cond: assert property (start_o |-> $past(ready_i && !err && no_fault
    && !fl[FN_PAUSE] && !fl[FN_STOP] && remote_en))
    else $error("start accepted outside its conditions");
  a_start_resp: assert property (s_start_edge ##0 (cmd_ok && ready_i && no_fault
    && !fl[FN_PAUSE] && !fl[FN_STOP]) |=> start_o)
    else $error("start edge with conditions met not acted on");
  a_stop_resp: assert property (s_stop_edge ##0 cmd_ok |=> stop_o)
    else $error("stop edge not acted on");
  a_pause_cond: assert property (pause_o |-> $past(running_i && cmd_ok))
    else $error("pause accepted while not running");
  a_cont_cond: assert property (continue_o |-> $past(paused_i && cmd_ok
    && !fl[FN_PAUSE] && !fl[FN_STOP]))
    else $error("continue accepted outside its conditions");
  a_reset_cond: assert property (reset_o |-> $past(ready_i && remote_en))
    else $error("reset accepted while not ready");
  a_mon_cond: assert property (motor_power_on_cmd_o |-> $past(ready_i && no_fault
    && !fl[FN_MOFF] && cmd_ok))
    else $error("motor on accepted outside its conditions");
  a_moff_cond: assert property (motor_power_off_cmd_o |-> $past(ready_i && cmd_ok))
    else $error("motor off accepted while not ready");
  a_home_cond: assert property (home_o |-> $past(ready_i && motors_energised_i
    && no_fault && cmd_ok && !fl[FN_PAUSE] && !fl[FN_STOP]))
    else $error("home accepted outside its conditions");
  a_func_num: assert property (start_o |-> func_num_o ==
    $past({fl[FN_SEL4], fl[FN_SEL2], fl[FN_SEL1]}))
    else $error("function number not captured with start");
  a_func_hold: assert property (!start_o |-> $stable(func_num_o))
    else $error("function number changed without start");
  a_remote_gate: assert property (!remote_en |=> !(start_o || stop_o || reset_o
    || pause_o || continue_o || home_o || motor_power_on_cmd_o || motor_power_off_cmd_o))
    else $error("command passed outside remote mode");
  a_err_fall: assert property ($fell(err) |-> reset_o)
    else $error("error cleared without accepted reset");
  a_err_rise: assert property (error_event_i |=> error_o)
    else $error("error event not shown");
  a_reset_clears: assert property (reset_o && !$past(error_event_i) |-> !err)
    else $error("accepted reset left error pending");
  a_sync_level: assert property ($rose(lvl[0]) |-> $past(sync2[0] && sync3[0]))
    else $error("level changed before two stages agreed");
  a_sync_settle: assert property (s_pin_settle ##0 $past(sync2[0]) |-> lvl[0])
    else $error("settled pin not taken as level");

endmodule : rcg_gate

// file: test/rcg_sequencer.sv
// Behavioural remote sequencer that drives the command pins
`timescale 1ns/1ns
module rcg_sequencer (
  input  wire logic       clk_i,
  output logic      [7:0] pin_o
);
  logic [7:0] held = 8'h00;
  logic [7:0] strobe = 8'h00;
  assign pin_o = held | strobe;
  // Select bits and held levels settle well before any strobe
  task automatic hold(input logic [7:0] lvl);
    @(posedge clk_i);
    #1 held = lvl;
  endtask : hold
  // Prompt or slow strobe, never shorter than the two-cycle glitch filter
  task automatic pulse(input int idx);
    int len;
    len = 2 + $urandom % 4;
    @(posedge clk_i);
    #1 strobe[idx] = 1'b1;
    repeat (len) @(posedge clk_i);
    #1 strobe = 8'h00;
  endtask : pulse
endmodule : rcg_sequencer

// file: test/tb_remote_input_command_gate.sv
// Self-checking bench for the remote input command gate
`timescale 1ns/1ns
`include "rcg_params.svh"
module tb_remote_input_command_gate;
  import rcg_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  pin_i, pin_o;
  logic        vio = 1'b1, asg = 1'b1, src = 1'b1, err_ev = 1'b0, err_m = 1'b0;
  logic        rdy = 1'b0, run = 1'b0, psd = 1'b0, est = 1'b0, grd = 1'b0, mot = 1'b0;
  logic [32:0] in_map = `RCG_IN_MAP_INIT;
  logic [10:0] in_asgn = `RCG_IN_ASGN_INIT;
  logic [17:0] out_map = `RCG_OUT_MAP_INIT;
  logic        rem_o, error_o, start_o, stop_o, pause_o, cont_o, reset_o, mon_o, moff_o, home_o;
  rcg_fnum_t   fnum;
  wire  [10:0] cmd = {home_o, moff_o, mon_o, reset_o, cont_o, pause_o, stop_o, 3'h0, start_o};
  int          num_errors = 0;
  int          check_count = 0;

  always #4 clk_i = ~clk_i;

  rcg_sequencer rcg_sequencer_inst (.clk_i(clk_i), .pin_o(pin_i));
  rcg_gate rcg_gate_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .pin_i(pin_i), .virtual_io_en_i(vio),
    .remote_assigned_i(asg), .remote_source_i(src), .in_map_i(in_map),
    .in_assigned_i(in_asgn), .out_map_i(out_map), .ready_i(rdy), .running_i(run),
    .paused_i(psd), .emergency_stop_active_i(est), .guard_open_active_i(grd),
    .motors_energised_i(mot), .error_event_i(err_ev), .pin_o(pin_o),
    .remote_enabled_out_o(rem_o), .error_o(error_o), .start_o(start_o), .func_num_o(fnum),
    .stop_o(stop_o), .pause_o(pause_o), .continue_o(cont_o), .reset_o(reset_o),
    .motor_power_on_cmd_o(mon_o), .motor_power_off_cmd_o(moff_o), .home_o(home_o));

  task automatic check_v(input logic [10:0] got, input logic [10:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t vector got %h expected %h", $time, got, exp);
    end
  endtask : check_v

  task automatic check_b(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : check_b

  // Pin 5 is pause and pin 4 is stop in both maps used here
  function automatic logic accept(input rcg_func_t f, input logic [7:0] lvl);
    logic hp;
    hp = lvl[5] | lvl[4];
    if (!(vio & asg & src) || (err_m && f != FN_RESET)) return 1'b0;
    case (f)
      FN_START: return rdy & ~est & ~grd & ~hp;
      FN_STOP:  return 1'b1;
      FN_PAUSE: return run;
      FN_CONT:  return psd & ~hp;
      FN_RESET: return rdy;
      // Motor off sits on pin 2 whenever motor on is assigned
      FN_MON:   return rdy & ~est & ~grd & ~lvl[2];
      FN_MOFF:  return rdy;
      default:  return rdy & mot & ~est & ~grd & ~hp;
    endcase
  endfunction : accept

  // Statuses onto pins by the output map; a shared pin shows their OR
  function automatic logic [7:0] exp_pins(input logic [5:0] st);
    exp_pins = 8'h00;
    for (int s = 0; s < 6; s++) begin
      if (st[s]) exp_pins[out_map[s*3 +: 3]] = 1'b1;
    end
  endfunction : exp_pins

  task automatic pulse_err();
    @(posedge clk_i);
    #1 err_ev = 1'b1;
    err_m = 1'b1;
    @(posedge clk_i);
    #1 err_ev = 1'b0;
  endtask : pulse_err

  task automatic fire(input rcg_func_t f, input logic [7:0] lvl);
    logic [10:0] seen;
    logic        exp;
    int          p;
    p = (f > FN_RESET) ? int'(f) - 7 : int'(f);
    lvl[p] = 1'b0;
    rcg_sequencer_inst.hold(lvl);
    repeat (5) @(posedge clk_i);
    exp = accept(f, lvl);
    seen = 11'h000;
    fork
      rcg_sequencer_inst.pulse(p);
      repeat (12) begin
        @(posedge clk_i);
        #1 seen = seen | cmd;
      end
    join
    check_v(seen, exp ? (11'h001 << f) : 11'h000);
    if (exp && f == FN_START) check_v({8'h00, fnum}, {8'h00, in_asgn[1] ? lvl[3:1] : 3'h0});
    if (exp && f == FN_RESET) err_m = 1'b0;
    check_b(error_o, err_m);
    check_b(rem_o, vio & asg & src);
    check_v({3'h0, pin_o}, {3'h0, exp_pins({grd, est, err_m, psd, run, rdy})});
  endtask : fire

  task automatic rand_run(input int n, input logic alt);
    int         k;
    logic [7:0] lvl;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      #1 rdy = ($urandom % 4) != 0;
      {run, psd, mot} = 3'($urandom);
      {est, grd} = (($urandom % 3) == 0) ? 2'($urandom) : 2'h0;
      {vio, asg, src} = (($urandom % 8) == 0) ? 3'($urandom) : 3'h7;
      if (($urandom % 6) == 0) pulse_err();
      k = $urandom % (alt ? 8 : 5);
      lvl = {2'h0, ($urandom % 6) == 0, ($urandom % 6) == 0, alt ? 3'h0 : 3'($urandom), 1'b0};
      fire(rcg_func_t'(k == 0 ? 0 : k + 3), lvl);
    end
  endtask : rand_run

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  initial begin
    void'($urandom(32'h62944c3f));
    repeat (8) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 {rdy, run, psd, mot} = 4'hf;
    pulse_err();
    fire(FN_START, 8'h04);
    fire(FN_STOP, 8'h00);
    fire(FN_RESET, 8'h00);
    fire(FN_START, 8'h0e);
    fire(FN_START, 8'h10);
    rand_run(60, 1'b0);
    // Pins go low first, since remapping onto a high pin makes an edge
    rcg_sequencer_inst.hold(8'h00);
    repeat (5) @(posedge clk_i);
    #1 in_map = `RCG_IN_MAP_INIT | 33'h0_d100_0000;
    in_asgn = 11'h7f1;
    // Ready moves to pin 7 and shares it with paused
    out_map = 18'h087f7;
    {rdy, run, psd, mot, est, grd, vio, asg, src} = 9'h1e7;
    fire(FN_RESET, 8'h00);
    fire(FN_MON, 8'h04);
    fire(FN_MON, 8'h00);
    fire(FN_HOME, 8'h20);
    rand_run(70, 1'b1);
    give_verdict();
  end

  initial begin
    #200000;
    num_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : tb_remote_input_command_gate
